/* irrc_top.sv */
// Infrared remote command receiver: frame check, code match, output stage, APB registers
//
// Summary of operation
// - Serial input is synchronised and squared by a hysteresis filter before sampling.
// - A command counts only after two successive frames are both checked.
// - The first frame shifts bit by bit into a twelve-bit reference register.
// - During the second frame each pushed-out bit is compared with the arriving bit.
// - The first mismatch resets reception at once and drops the command.
// - Each bit is sampled by a shift pulse at the centre of its period.
// - Matching code bits produce a latch strobe that loads the output stage.
// - Mismatching code bits produce no strobe; outputs keep their current state.
// - Small variants compare code bits two and three, large compares one and two.
// - The uncompared code bit is held at one internally and must arrive as one.
// - An accepted single-shot command raises its pulse output for about 107 ms.
// - First strobe after key press raises the hold output; repeats keep it high.
// - Hold output falls about 160 ms after the last accepted frame.
// - Several hold outputs may be high together from one frame.
// - Each accepted toggle command inverts its toggle output, except in the inverted-input variant while hold one or two is high.
// - Frame holds three code bits, hold flag, two group flags, six key bits.
// - Group A drives singles 1-6; group B keys 1-4 singles 7-10, keys 5-6 toggles.
// - Ten-output variants decode only hold 1-5 plus a reduced single or toggle set.
// - Power-on initialisation is triggered while the code pin nodes are still low.
// - One 38 kHz tick times both sequencing and bit sampling.
// - Inverted-input variant forces toggle one low while hold one or two is high.
`timescale 1ns/1ns
module irrc_top #(
  parameter int SINGLE_LEN = irrc_pkg::SINGLE_TICKS,
  parameter int HOLD_LEN = irrc_pkg::HOLD_TICKS,
  parameter int TICK_LEN = irrc_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Receiver pins
  input wire logic rx_in,
  input wire logic code_pin_a,
  input wire logic code_pin_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command outputs
  output logic [5:0] hold_level_out,
  output logic [9:0] single_pulse_out,
  output logic [1:0] toggle_out
);
  import irrc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Key K1 sits in the highest key field bit; outputs count from bit 0
  function automatic logic [5:0] key_vec(input logic [11:0] f);
    logic [5:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) begin
      v[i] = f[FB_KEY_HI - i];
    end
    return v;
  endfunction : key_vec

  function automatic logic code_match(input logic [11:0] f, input irrc_variant_t var_sel,
                                      input logic pa, input logic pb);
    logic ok;
    ok = 1'b0;
    if (var_sel == IRRC_VAR_LARGE) begin
      ok = (f[FB_MATCH_FIRST] == pa) && (f[FB_MATCH_SECOND] == pb)
           && f[FB_MATCH_THIRD];
    end else begin
      ok = f[FB_MATCH_FIRST] && (f[FB_MATCH_SECOND] == pa)
           && (f[FB_MATCH_THIRD] == pb);
    end
    return ok;
  endfunction : code_match

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rx_s1_r, rx_s2_r, pa_s1_r, pa_s2_r, pb_s1_r, pb_s2_r;
  logic rx_filt_r, rx_prev_r;
  logic [1:0] filt_cnt_r;
  logic [9:0] div_r;
  logic tick_r, div_end;
  irrc_state_t state_r;
  logic [11:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] smp_r;
  logic [7:0] gap_r;
  logic accept_r;
  logic [11:0] frame_r;
  logic code_ok_r;
  logic [2:0] ctrl_r;
  logic [31:0] single_cnt_r;
  logic [31:0] hold_cnt_r;
  logic [15:0] acc_cnt_r;
  logic [15:0] rej_cnt_r;
  logic init_busy;
  logic rx_pol;
  logic rise;
  logic sample;
  logic strobe;
  irrc_variant_t var_sel;
  logic [5:0] keys;
  logic [5:0] hold_mask;
  logic [9:0] single_mask;
  logic [1:0] toggle_mask;
  logic [5:0] hold_nxt;
  logic [9:0] single_nxt;
  logic apb_wr;
  logic [31:0] rd_nxt;
  logic rd_err;

  // ----------------------------------------------------------------
  // Pin synchronisers and hysteresis filter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_s1_r <= 1'b0;
      rx_s2_r <= 1'b0;
      pa_s1_r <= 1'b0;
      pa_s2_r <= 1'b0;
      pb_s1_r <= 1'b0;
      pb_s2_r <= 1'b0;
    end else begin
      rx_s1_r <= rx_in;
      rx_s2_r <= rx_s1_r;
      pa_s1_r <= code_pin_a;
      pa_s2_r <= pa_s1_r;
      pb_s1_r <= code_pin_b;
      pb_s2_r <= pb_s1_r;
    end
  end

  assign var_sel = irrc_variant_t'(ctrl_r[1:0]);
  assign rx_pol = (var_sel == IRRC_VAR_SMALL_INV) ? ~rx_s2_r : rx_s2_r;
  // Both strap nodes low means the pull-up capacitors are still charging
  assign init_busy = ~(pa_s2_r | pb_s2_r);

  // A level must persist three clocks to flip the filter, so slow ramps
  // and short glitches cannot chatter the edge detector
  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_cnt_r <= 2'h0;
      rx_filt_r <= 1'b0;
      rx_prev_r <= 1'b0;
    end else begin
      rx_prev_r <= rx_filt_r;
      if (rx_pol == rx_filt_r) begin
        filt_cnt_r <= 2'h0;
      end else if (filt_cnt_r == SCHMITT_LAST) begin
        filt_cnt_r <= 2'h0;
        rx_filt_r <= rx_pol;
      end else begin
        filt_cnt_r <= filt_cnt_r + 2'h1;
      end
    end
  end

  assign rise = rx_filt_r & ~rx_prev_r;

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r <= 10'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_end;
      div_r <= div_end ? 10'h000 : div_r + 10'h001;
    end
  end

  assign div_end = (div_r == 10'(TICK_LEN - 1));
  assign sample = tick_r && (smp_r == 8'h01);

  // ----------------------------------------------------------------
  // Frame reception and double check
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || init_busy || !ctrl_r[CTRL_ENABLE_BIT]) begin
      state_r <= IRRC_IDLE;
      shift_r <= 12'h000;
      bit_cnt_r <= 4'h0;
      smp_r <= 8'h00;
      gap_r <= 8'h00;
      accept_r <= 1'b0;
    end else begin
      accept_r <= 1'b0;
      case (state_r)
        IRRC_IDLE: begin
          if (rise) begin
            state_r <= IRRC_RX_FIRST;
            shift_r <= 12'h000;
            bit_cnt_r <= 4'h0;
            smp_r <= FIRST_SAMPLE_TICKS;
          end
        end
        IRRC_RX_FIRST: begin
          if (sample) begin
            shift_r <= {shift_r[10:0], rx_filt_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            smp_r <= BIT_TICKS;
            if (bit_cnt_r == FRAME_LAST) begin
              state_r <= IRRC_GAP;
              gap_r <= GAP_TICKS;
            end
          end else if (tick_r) begin
            smp_r <= smp_r - 8'h01;
          end
        end
        IRRC_GAP: begin
          if (rise) begin
            state_r <= IRRC_RX_SECOND;
            bit_cnt_r <= 4'h0;
            smp_r <= FIRST_SAMPLE_TICKS;
          end else if (tick_r) begin
            gap_r <= gap_r - 8'h01;
            if (gap_r == 8'h01) begin
              state_r <= IRRC_IDLE;
              shift_r <= 12'h000;
            end
          end
        end
        IRRC_RX_SECOND: begin
          if (sample) begin
            if (shift_r[FRAME_BITS - 1] != rx_filt_r) begin
              state_r <= IRRC_IDLE;
              shift_r <= 12'h000;
            end else begin
              shift_r <= {shift_r[10:0], rx_filt_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
              smp_r <= BIT_TICKS;
              if (bit_cnt_r == FRAME_LAST) begin
                state_r <= IRRC_IDLE;
                accept_r <= 1'b1;
              end
            end
          end else if (tick_r) begin
            smp_r <= smp_r - 8'h01;
          end
        end
        default: begin
          state_r <= IRRC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Code comparison and latch strobe
  // ----------------------------------------------------------------
  assign strobe = accept_r && code_match(shift_r, var_sel, pa_s2_r, pb_s2_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_r <= 12'h000;
      code_ok_r <= 1'b0;
      acc_cnt_r <= 16'h0000;
      rej_cnt_r <= 16'h0000;
    end else if (accept_r) begin
      frame_r <= shift_r;
      code_ok_r <= strobe;
      if (strobe) begin
        acc_cnt_r <= acc_cnt_r + 16'h0001;
      end else begin
        rej_cnt_r <= rej_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  assign keys = key_vec(shift_r);

  always_comb begin
    case (var_sel)
      IRRC_VAR_LARGE: begin
        hold_mask = 6'h3f;
        single_mask = 10'h3ff;
        toggle_mask = 2'h3;
      end
      IRRC_VAR_SMALL: begin
        hold_mask = 6'h1f;
        single_mask = 10'h01f;
        toggle_mask = 2'h0;
      end
      default: begin
        hold_mask = 6'h1f;
        single_mask = 10'h007;
        toggle_mask = 2'h3;
      end
    endcase
  end

  assign hold_nxt = shift_r[FB_HOLD] ? (keys & hold_mask) : 6'h00;
  assign single_nxt = ((shift_r[FB_GROUP_A] ? {4'h0, keys} : 10'h000)
                       | (shift_r[FB_GROUP_B] ? {keys[3:0], 6'h00} : 10'h000))
                      & single_mask;

  // Single pulses share one timer; a newer command restarts it
  always_ff @(posedge core_clk) begin
    if (rst || init_busy) begin
      single_pulse_out <= 10'h000;
      single_cnt_r <= 32'h0000_0000;
    end else if (strobe && (single_nxt != 10'h000)) begin
      single_pulse_out <= single_nxt;
      single_cnt_r <= 32'(SINGLE_LEN);
    end else if (tick_r && (single_cnt_r != 32'h0000_0000)) begin
      single_cnt_r <= single_cnt_r - 32'h0000_0001;
      if (single_cnt_r == 32'h0000_0001) begin
        single_pulse_out <= 10'h000;
      end
    end
  end

  // Each accepted repeat reloads the release timer
  always_ff @(posedge core_clk) begin
    if (rst || init_busy) begin
      hold_level_out <= 6'h00;
      hold_cnt_r <= 32'h0000_0000;
    end else if (strobe && (hold_nxt != 6'h00)) begin
      hold_level_out <= hold_nxt;
      hold_cnt_r <= 32'(HOLD_LEN);
    end else if (tick_r && (hold_cnt_r != 32'h0000_0000)) begin
      hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
      if (hold_cnt_r == 32'h0000_0001) begin
        hold_level_out <= 6'h00;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || init_busy) begin
      toggle_out <= 2'h0;
    end else if ((var_sel == IRRC_VAR_SMALL_INV) && (hold_level_out[1:0] != 2'h0)) begin
      toggle_out <= {toggle_out[1], 1'b0};
    end else if (strobe && shift_r[FB_GROUP_B]) begin
      toggle_out <= toggle_out ^ (keys[5:4] & toggle_mask);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state on every access
  // ----------------------------------------------------------------
  assign apb_wr = psel && penable && pready && pwrite;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      OFS_CTRL: rd_nxt = {29'h0000_0000, ctrl_r};
      OFS_STATUS: rd_nxt = {26'h000_0000, pb_s2_r, pa_s2_r, init_busy, state_r};
      OFS_FRAME: rd_nxt = {15'h0000, code_ok_r, 4'h0, frame_r};
      OFS_OUTS: rd_nxt = {14'h0000, toggle_out, single_pulse_out, hold_level_out};
      OFS_COUNT: rd_nxt = {rej_cnt_r, acc_cnt_r};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr <= rd_err || (pwrite && (paddr != OFS_CTRL));
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Variant and receive enable steer the whole decoder
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_wr && (paddr == OFS_CTRL)) begin
      ctrl_r <= pwdata[2:0];
    end
  end

endmodule : irrc_top

/* irrc_pkg.sv */
// Shared constants and types for the infrared command receiver
package irrc_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 38_000;
  localparam int TICK_DIV = CLK_HZ / OSC_HZ;
  localparam logic [9:0] TICK_LAST = 10'(TICK_DIV - 1);
  localparam int SINGLE_MS = 107;
  localparam int HOLD_MS = 160;
  localparam int SINGLE_TICKS = SINGLE_MS * OSC_HZ / 1000;
  localparam int HOLD_TICKS = HOLD_MS * OSC_HZ / 1000;

  // ----------------------------------------------------------------
  // Frame timing in oscillator ticks; filter length in clocks
  // ----------------------------------------------------------------
  localparam logic [7:0] BIT_TICKS = 8'h10;
  localparam logic [7:0] FIRST_SAMPLE_TICKS = 8'h18;
  localparam logic [7:0] GAP_TICKS = 8'h60;
  localparam logic [1:0] SCHMITT_LAST = 2'h2;
  localparam int FRAME_BITS = 12;
  localparam logic [3:0] FRAME_LAST = 4'hb;

  // ----------------------------------------------------------------
  // Frame field positions (first received bit lands in bit 11)
  // ----------------------------------------------------------------
  localparam int FB_MATCH_FIRST = 11;
  localparam int FB_MATCH_SECOND = 10;
  localparam int FB_MATCH_THIRD = 9;
  localparam int FB_HOLD = 8;
  localparam int FB_GROUP_A = 7;
  localparam int FB_GROUP_B = 6;
  localparam int FB_KEY_HI = 5;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_FRAME = 12'h008;
  localparam logic [11:0] OFS_OUTS = 12'h00c;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam int CTRL_ENABLE_BIT = 2;

  typedef enum logic [1:0] {
    IRRC_VAR_LARGE,
    IRRC_VAR_SMALL,
    IRRC_VAR_SMALL_TOGGLE,
    IRRC_VAR_SMALL_INV
  } irrc_variant_t;

  typedef enum logic [2:0] {
    IRRC_IDLE,
    IRRC_RX_FIRST,
    IRRC_GAP,
    IRRC_RX_SECOND
  } irrc_state_t;

endpackage : irrc_pkg

/* irrc_checker.sv */
// Port checker for the infrared command receiver
`timescale 1ns/1ns
module irrc_checker #(
  parameter int SINGLE_LEN = 20,
  parameter int HOLD_LEN = 40,
  parameter int TICK_LEN = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Receiver pins
  input wire logic rx_in,
  input wire logic code_pin_a,
  input wire logic code_pin_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Command outputs
  input wire logic [5:0] hold_level_out,
  input wire logic [9:0] single_pulse_out,
  input wire logic [1:0] toggle_out
);
  import irrc_pkg::*;
  // ----------------------------------------------------------------
  // Pulse length counters
  // ----------------------------------------------------------------
  // One tick of slack either way: the tick phase at acceptance is free
  localparam int S_LO = (SINGLE_LEN - 1) * TICK_LEN;
  localparam int S_HI = (SINGLE_LEN + 1) * TICK_LEN;
  localparam int H_LO = (HOLD_LEN - 1) * TICK_LEN;
  int s_cnt_r;
  int h_cnt_r;
  always_ff @(posedge core_clk) begin
    s_cnt_r <= (rst || single_pulse_out == 10'h0) ? 0 : s_cnt_r + 1;
  end
  always_ff @(posedge core_clk) begin
    h_cnt_r <= (rst || hold_level_out == 6'h0) ? 0 : h_cnt_r + 1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_reset_clear;
    $fell(rst) |-> ({toggle_out, single_pulse_out, hold_level_out} == 18'h0 && !pready);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs set after reset");
  property p_init_clear;
    !(code_pin_a || code_pin_b) [*5] |-> {toggle_out, single_pulse_out, hold_level_out} == 18'h0;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("outputs set during init");
  property p_single_len;
    $fell(|single_pulse_out) |-> (s_cnt_r >= S_LO && s_cnt_r <= S_HI);
  endproperty
  a_single_len: assert property (p_single_len) else $error("single pulse length");
  // Repeats reload the hold timer, so only the lower bound is fixed
  property p_hold_len;
    $fell(|hold_level_out) && $past(code_pin_a | code_pin_b, 3) |-> h_cnt_r >= H_LO;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold fell early");
  property p_toggle_once;
    $changed(toggle_out) |=> $stable(toggle_out) [*8];
  endproperty
  a_toggle_once: assert property (p_toggle_once) else $error("toggle output chatter");
  property p_pready_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("pready late");
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
  property p_err_with_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr alone");
  property p_prdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("prdata outside answer");
endmodule : irrc_checker

/* irrc_tx_model.sv */
// Transmitter model: start bit, twelve data bits, two copies per command
`timescale 1ns/1ns
module irrc_tx_model #(
  parameter int TICK_LEN = irrc_pkg::TICK_DIV
) (
  // Clock
  input wire logic core_clk,
  // Serial line, idle low unless inverted for the inverted-input variant
  output logic rx_line
);
  import irrc_pkg::*;
  logic lvl = 1'b0;
  logic inv = 1'b0;
  assign rx_line = lvl ^ inv;
  task automatic invert(input logic v);
    inv <= v;
  endtask : invert
  task automatic ticks(input int n);
    repeat (n * TICK_LEN) @(posedge core_clk);
  endtask : ticks
  task automatic frame(input logic [11:0] f);
    lvl <= 1'b1;
    ticks(16);
    for (int i = 11; i >= 0; i--) begin
      lvl <= f[i];
      ticks(16);
    end
    // Line drops so the next start bit makes a fresh rising edge
    lvl <= 1'b0;
    ticks(8);
  endtask : frame
  task automatic send_cmd(input logic [11:0] f1, input logic [11:0] f2);
    frame(f1);
    frame(f2);
  endtask : send_cmd
endmodule : irrc_tx_model

/* irrc_top_tb.sv */
// Self-checking testbench for the infrared command receiver
`timescale 1ns/1ns
module irrc_top_tb;
  import irrc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk, rst, rx_in, code_pin_a, code_pin_b, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic [5:0] hold_level_out;
  logic [9:0] single_pulse_out;
  logic [1:0] toggle_out;
  int miscompares = 0;
  int n_checks = 0;
  logic [11:0] row_f [7] = '{12'haa0, 12'ha60, 12'hb28, 12'ha42, 12'ha44, 12'ha41, 12'ha42};
  logic [17:0] row_e [7] = '{18'h0_0040, 18'h0_1000, 18'h0_0005, 18'h1_0000, 18'h1_8000,
    18'h3_0000, 18'h2_0000};
  irrc_top #(.SINGLE_LEN(20), .HOLD_LEN(40), .TICK_LEN(8)) irrc_top_inst (
    .core_clk(core_clk), .rst(rst), .rx_in(rx_in), .code_pin_a(code_pin_a),
    .code_pin_b(code_pin_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hold_level_out(hold_level_out), .single_pulse_out(single_pulse_out),
    .toggle_out(toggle_out));
  irrc_tx_model #(.TICK_LEN(8)) irrc_tx_model_inst (.core_clk(core_clk), .rx_line(rx_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Only the watchdog ends a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = wr ? 32'h0 : prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic chk_bus(input logic [32:0] exp);
    n_checks++;
    if ({er, rd} !== exp) begin
      miscompares++;
      $display("mismatch at %0t: bus %h, expected %h", $time, {er, rd}, exp);
    end
  endtask : chk_bus
  task automatic chk_outs(input logic [17:0] exp);
    n_checks++;
    if ({toggle_out, single_pulse_out, hold_level_out} !== exp) begin
      miscompares++;
      $display("mismatch at %0t: outputs %h, expected %h", $time,
        {toggle_out, single_pulse_out, hold_level_out}, exp);
    end
  endtask : chk_outs
  // Singles and holds must have lapsed after the wait; toggles persist
  task automatic cmd(input logic [11:0] f1, input logic [11:0] f2, input logic [17:0] exp);
    irrc_tx_model_inst.send_cmd(f1, f2);
    chk_outs(exp);
    irrc_tx_model_inst.ticks(45);
    chk_outs(exp & 18'h3_0000);
  endtask : cmd
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // About 60k clocks of traffic; the rest is slack
  initial begin
    repeat (80_000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
  initial begin
    {rst, code_pin_a, code_pin_b, psel, penable, pwrite} = 6'b10_0000;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk_outs(18'h0_0000);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_bus(33'h0_0000_0004);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_bus(33'h0_0000_0008);
    apb(1'b0, 12'h014, 32'h0);
    chk_bus(33'h1_0000_0000);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    chk_bus(33'h1_0000_0000);
    code_pin_a <= 1'b1;
    repeat (10) @(posedge core_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_bus(33'h0_0000_0010);
    for (int i = 0; i < 7; i++) begin
      cmd(row_f[i], row_f[i], row_e[i]);
    end
    cmd(12'hea0, 12'hea0, 18'h2_0000);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk_bus(33'h0_0001_0007);
    cmd(12'h8a0, 12'h8a0, 18'h2_0000);
    irrc_tx_model_inst.send_cmd(12'haa0, 12'hab0);
    chk_outs(18'h2_0000);
    cmd(12'ha90, 12'ha90, 18'h2_0080);
    apb(1'b0, OFS_FRAME, 32'h0);
    chk_bus(33'h0_0001_0a90);
    apb(1'b1, OFS_CTRL, 32'h0000_0006);
    chk_bus(33'h0_0000_0000);
    cmd(12'hca0, 12'hca0, 18'h2_0040);
    apb(1'b1, OFS_CTRL, 32'h0000_0005);
    chk_bus(33'h0_0000_0000);
    cmd(12'hc84, 12'hc84, 18'h2_0200);
    // Receiver off while the line polarity flips, so the swap is not taken as a start bit
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    chk_bus(33'h0_0000_0000);
    irrc_tx_model_inst.invert(1'b1);
    repeat (10) @(posedge core_clk);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    chk_bus(33'h0_0000_0000);
    cmd(12'hc42, 12'hc42, 18'h3_0000);
    cmd(12'hd20, 12'hd20, 18'h2_0001);
    irrc_tx_model_inst.invert(1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk_outs(18'h0_0000);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk_bus(33'h0_0000_0004);
    conclude();
  end
endmodule : irrc_top_tb

bind irrc_top irrc_checker #(.SINGLE_LEN(SINGLE_LEN), .HOLD_LEN(HOLD_LEN),
  .TICK_LEN(TICK_LEN)) irrc_checker_inst (
  .core_clk(core_clk), .rst(rst), .rx_in(rx_in), .code_pin_a(code_pin_a),
  .code_pin_b(code_pin_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hold_level_out(hold_level_out), .single_pulse_out(single_pulse_out),
  .toggle_out(toggle_out));
